/* config_seq_pkg.sv */
package config_seq_pkg;

  localparam int CLOCK_MHZ = 10;
  // clear time is not fixed by the pins; plain default
  localparam int INIT_CLEAR_TIME_NS = 5000;
  localparam int INIT_CLEAR_CYCLES =
    (INIT_CLEAR_TIME_NS * CLOCK_MHZ + 999) / 1000;
  localparam int INIT_CNT_W = 13;
  localparam logic [INIT_CNT_W-1:0] INIT_CLEAR_COUNT =
    INIT_CNT_W'(INIT_CLEAR_CYCLES);
  localparam logic [INIT_CNT_W-1:0] INIT_CNT_RESET = 13'h0000;

  localparam int PORT_COUNT = 4;
  localparam int USER_FF_COUNT = 8;
  localparam logic [USER_FF_COUNT-1:0] USER_FF_FORCE_VALUE = 8'h0f;
  localparam logic [USER_FF_COUNT-1:0] USER_FF_RESET = 8'h0f;

  // sync bit order: {reconfigure request (low active), done, init status}
  localparam int SYNC_W = 3;
  localparam int SYNC_INIT = 0;
  localparam int SYNC_DONE = 1;
  localparam int SYNC_RECONF = 2;
  localparam logic [SYNC_W-1:0] SYNC_RESET_VALUE = 3'h4;

  typedef enum logic [3:0] {
    ST_RESET,
    ST_INIT,
    ST_CONFIG,
    ST_ERROR,
    ST_WAKE_OUTPUTS,
    ST_WAKE_RELEASE,
    ST_WAKE_SETTLE,
    ST_WAKE_DONE,
    ST_USER
  } seq_state_t;

  typedef enum logic [1:0] {
    PORT_JTAG,
    PORT_SPI,
    PORT_I2C,
    PORT_WISHBONE
  } config_port_t;

  typedef enum logic [1:0] {
    OP_NVM_READ,
    OP_NVM_WRITE,
    OP_SRAM_READ,
    OP_SRAM_WRITE
  } access_op_t;

endpackage : config_seq_pkg

/* pin_sync.sv */
`timescale 1ns/1ps

module pin_sync #(
  parameter int                 WIDTH       = 3,
  parameter logic [WIDTH-1:0]   RESET_VALUE = '0
) (
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinOut
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  // first stage feeds only the second one
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      stage1_reg <= RESET_VALUE;
      stage2_reg <= RESET_VALUE;
    end
    else
    begin
      stage1_reg <= pinIn;
      stage2_reg <= stage1_reg;
    end
  end

  assign pinOut = stage2_reg;

endmodule : pin_sync

/* port_access_gate.sv */
`timescale 1ns/1ps

module port_access_gate (
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic [3:0] portRequest,
  input  wire logic       transparentMode,
  input  wire logic       userMode,
  input  wire logic       nvmReadReq,
  input  wire logic       nvmWriteReq,
  input  wire logic       sramReadReq,
  input  wire logic       sramWriteReq,
  output logic      [1:0] portOwner,
  output logic            portOwnerValid,
  output logic            nvmReadGrant,
  output logic            nvmWriteGrant,
  output logic            sramReadGrant,
  output logic            sramWriteGrant
);

  logic [1:0] owner_reg;
  logic       ownerValid_reg;
  logic [1:0] pick;
  logic       anyReq;
  logic [3:0] grant_reg;
  logic [3:0] opReq;
  logic       ownerLive;

  function automatic logic allowed(input logic [1:0] port,
                                   input logic [1:0] op,
                                   input logic       transp);
    case (port)
      config_seq_pkg::PORT_JTAG:
        allowed = 1'b1;
      config_seq_pkg::PORT_SPI,
      config_seq_pkg::PORT_I2C:
        allowed = (op != config_seq_pkg::OP_SRAM_READ);
      config_seq_pkg::PORT_WISHBONE:
        allowed = transp && (op == config_seq_pkg::OP_NVM_READ ||
                             op == config_seq_pkg::OP_NVM_WRITE);
      default:
        allowed = 1'b0;
    endcase
  endfunction : allowed

  // lowest index wins; boundary scan has top priority
  always_comb
  begin
    pick = 2'h0;
    anyReq = |portRequest;
    for (int i = config_seq_pkg::PORT_COUNT - 1; i >= 0; i--)
    begin
      if (portRequest[i])
        pick = 2'(i);
    end
  end

  // one owner at a time; a later requester waits, never preempts
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      owner_reg <= 2'h0;
      ownerValid_reg <= 1'b0;
    end
    else if (!ownerValid_reg)
    begin
      owner_reg <= pick;
      ownerValid_reg <= anyReq;
    end
    else if (!portRequest[owner_reg])
      ownerValid_reg <= 1'b0;
  end

  assign opReq = {sramWriteReq, sramReadReq, nvmWriteReq, nvmReadReq};
  // transparent access only while the user design keeps running
  assign ownerLive = ownerValid_reg && portRequest[owner_reg] &&
                     (!transparentMode || userMode);

  for (genvar g = 0; g < 4; g++)
  begin : gen_grant
    always_ff @(posedge clock)
    begin
      if (!rstn)
        grant_reg[g] <= 1'b0;
      else
        grant_reg[g] <= ownerLive && opReq[g] &&
                        allowed(owner_reg, 2'(g), transparentMode);
    end
  end

  assign portOwner      = owner_reg;
  assign portOwnerValid = ownerValid_reg;
  assign nvmReadGrant   = grant_reg[0];
  assign nvmWriteGrant  = grant_reg[1];
  assign sramReadGrant  = grant_reg[2];
  assign sramWriteGrant = grant_reg[3];

endmodule : port_access_gate

/* config_state_sequencer.sv */
`timescale 1ns/1ps

// Functional notes
// - during power-on reset every external pin floats
// - after reset release, drive init status and done low, enter init
// - init clears sram; exit after clear time, no request, pin free
// - configuration starts on the init status rising edge
// - fetch from internal memory or spi flash; stay if none valid
// - init status high while loading; low on data error, no start
// - all data in sets done bit, starting four phase wake-up
// - wake phase one releases global output enable
// - wake phase two releases set/reset and ram write block
// - set/reset forces enabled flops to their defined value
// - ram write block overrides every ram write enable
// - last phase releases done; wait for high only if enabled
// - init status and done pins drive only when enabled
// - user mode after wake-up until request, reload or power loss
// - any re-init trigger drives both pins low, back to init
// - reload from the active configuration port re-initializes
// - only boundary scan reads sram; limits per port
// - boundary scan reaches both memories, offline or transparent
// - transparent mode updates flash while user mode runs
module config_state_sequencer (
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       initStatusIn,
  output logic            initStatusOut,
  output logic            initStatusOeN,
  input  wire logic       doneIn,
  output logic            doneOut,
  output logic            doneOeN,
  input  wire logic       reconfigureRequestPinN,
  input  wire logic       initStatusPinEnable,
  input  wire logic       donePinEnable,
  input  wire logic       nvmConfigValid,
  input  wire logic       spiConfigValid,
  output logic            fetchRequest,
  output logic            fetchFromSpi,
  input  wire logic       cfgDataDone,
  input  wire logic       cfgDataError,
  output logic            sramClear,
  output logic            ioHighZ,
  output logic            globalOutputEnable,
  output logic            globalSetReset,
  output logic            globalRamWriteBlock,
  output logic            internalDone,
  output logic            userMode,
  output logic            configError,
  input  wire logic [3:0] portRequest,
  input  wire logic [3:0] portReload,
  input  wire logic       transparentMode,
  input  wire logic       nvmReadReq,
  input  wire logic       nvmWriteReq,
  input  wire logic       sramReadReq,
  input  wire logic       sramWriteReq,
  output logic      [1:0] portOwner,
  output logic            portOwnerValid,
  output logic            nvmReadGrant,
  output logic            nvmWriteGrant,
  output logic            sramReadGrant,
  output logic            sramWriteGrant,
  input  wire logic       userRamWeIn,
  output logic            userRamWe,
  input  wire logic [7:0] userFfD,
  input  wire logic [7:0] forceEnableMask,
  output logic      [7:0] userFfQ
);

  config_seq_pkg::seq_state_t state_reg;
  config_seq_pkg::seq_state_t state_next;

  logic [config_seq_pkg::SYNC_W-1:0]     pinRaw;
  logic [config_seq_pkg::SYNC_W-1:0]     pinSync;
  logic [config_seq_pkg::INIT_CNT_W-1:0] initCnt_reg;
  logic                                  clearDone;
  logic                                  initSeenLow_reg;
  logic                                  initHigh;
  logic                                  doneHigh;
  logic                                  reconfAsserted;
  logic                                  reloadSeen;
  logic                                  reinit;
  logic                                  initReady;
  logic                                  sourceValid;
  logic                                  initDriveLow;
  logic                                  doneDriveLow;
  logic                                  initOeN_reg;
  logic                                  doneOeN_reg;
  logic                                  outEnable_reg;
  logic                                  setReset_reg;
  logic                                  gwb_reg;
  logic                                  doneBit_reg;
  logic                                  fetch_reg;
  logic                                  fromSpi_reg;
  logic                                  sramClear_reg;
  logic                                  user_reg;
  logic                                  error_reg;
  logic [7:0]                            ffQ_reg;

  // open drain: pull low when asked and enabled, else float
  function automatic logic odOeN(input logic enable,
                                 input logic driveLow);
    odOeN = !(enable && driveLow);
  endfunction : odOeN

  assign pinRaw[config_seq_pkg::SYNC_INIT]   = initStatusIn;
  assign pinRaw[config_seq_pkg::SYNC_DONE]   = doneIn;
  assign pinRaw[config_seq_pkg::SYNC_RECONF] = reconfigureRequestPinN;

  pin_sync #(
    .WIDTH       (config_seq_pkg::SYNC_W),
    .RESET_VALUE (config_seq_pkg::SYNC_RESET_VALUE)
  ) u_pin_sync (
    .clock  (clock),
    .rstn   (rstn),
    .pinIn  (pinRaw),
    .pinOut (pinSync)
  );

  port_access_gate u_port_access_gate (
    .clock           (clock),
    .rstn            (rstn),
    .portRequest     (portRequest),
    .transparentMode (transparentMode),
    .userMode        (user_reg),
    .nvmReadReq      (nvmReadReq),
    .nvmWriteReq     (nvmWriteReq),
    .sramReadReq     (sramReadReq),
    .sramWriteReq    (sramWriteReq),
    .portOwner       (portOwner),
    .portOwnerValid  (portOwnerValid),
    .nvmReadGrant    (nvmReadGrant),
    .nvmWriteGrant   (nvmWriteGrant),
    .sramReadGrant   (sramReadGrant),
    .sramWriteGrant  (sramWriteGrant)
  );

  assign initHigh       = pinSync[config_seq_pkg::SYNC_INIT];
  assign doneHigh       = pinSync[config_seq_pkg::SYNC_DONE];
  assign reconfAsserted = !pinSync[config_seq_pkg::SYNC_RECONF];
  assign clearDone      = (initCnt_reg >= config_seq_pkg::INIT_CLEAR_COUNT);
  // a reload only counts from the port that owns the logic
  assign reloadSeen     = portOwnerValid && portReload[portOwner];
  assign reinit         = reconfAsserted || reloadSeen;
  assign sourceValid    = nvmConfigValid || spiConfigValid;

  // a disabled pin cannot hold the sequence back
  assign initReady = !initStatusPinEnable ||
                     (initHigh && initSeenLow_reg);

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      config_seq_pkg::ST_RESET:
        state_next = config_seq_pkg::ST_INIT;
      config_seq_pkg::ST_INIT:
      begin
        if (clearDone && !reconfAsserted && initReady)
          state_next = config_seq_pkg::ST_CONFIG;
      end
      config_seq_pkg::ST_CONFIG:
      begin
        if (reinit)
          state_next = config_seq_pkg::ST_INIT;
        else if (sourceValid && cfgDataError)
          state_next = config_seq_pkg::ST_ERROR;
        else if (sourceValid && cfgDataDone)
          state_next = config_seq_pkg::ST_WAKE_OUTPUTS;
      end
      config_seq_pkg::ST_ERROR:
      begin
        if (reinit)
          state_next = config_seq_pkg::ST_INIT;
      end
      config_seq_pkg::ST_WAKE_OUTPUTS:
        state_next = reinit ? config_seq_pkg::ST_INIT
                            : config_seq_pkg::ST_WAKE_RELEASE;
      config_seq_pkg::ST_WAKE_RELEASE:
        state_next = reinit ? config_seq_pkg::ST_INIT
                            : config_seq_pkg::ST_WAKE_SETTLE;
      config_seq_pkg::ST_WAKE_SETTLE:
        state_next = reinit ? config_seq_pkg::ST_INIT
                            : config_seq_pkg::ST_WAKE_DONE;
      config_seq_pkg::ST_WAKE_DONE:
      begin
        if (reinit)
          state_next = config_seq_pkg::ST_INIT;
        else if (!donePinEnable || doneHigh)
          state_next = config_seq_pkg::ST_USER;
      end
      config_seq_pkg::ST_USER:
      begin
        if (reinit)
          state_next = config_seq_pkg::ST_INIT;
      end
      default:
        state_next = config_seq_pkg::ST_RESET;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
      state_reg <= config_seq_pkg::ST_RESET;
    else
      state_reg <= state_next;
  end

  // clear timer restarts on every entry to init
  always_ff @(posedge clock)
  begin
    if (!rstn)
      initCnt_reg <= config_seq_pkg::INIT_CNT_RESET;
    else if (state_reg != config_seq_pkg::ST_INIT)
      initCnt_reg <= config_seq_pkg::INIT_CNT_RESET;
    else if (!clearDone)
      initCnt_reg <= initCnt_reg + 13'h0001;
  end

  // low seen first, so a later high is a true rising edge
  always_ff @(posedge clock)
  begin
    if (!rstn)
      initSeenLow_reg <= 1'b0;
    else if (state_reg == config_seq_pkg::ST_INIT && !initHigh)
      initSeenLow_reg <= 1'b1;
    else if (state_reg != config_seq_pkg::ST_INIT)
      initSeenLow_reg <= 1'b0;
  end

  // pin drive follows the next state so it lines up with the move
  always_comb
  begin
    initDriveLow = 1'b0;
    doneDriveLow = 1'b1;
    case (state_next)
      config_seq_pkg::ST_RESET:
        doneDriveLow = 1'b1;
      config_seq_pkg::ST_INIT:
        initDriveLow = !clearDone || state_reg != config_seq_pkg::ST_INIT;
      config_seq_pkg::ST_ERROR:
        initDriveLow = 1'b1;
      config_seq_pkg::ST_WAKE_DONE,
      config_seq_pkg::ST_USER:
        doneDriveLow = 1'b0;
      default:
        initDriveLow = 1'b0;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      initOeN_reg <= 1'b1;
      doneOeN_reg <= 1'b1;
    end
    else
    begin
      initOeN_reg <= odOeN(initStatusPinEnable, initDriveLow);
      doneOeN_reg <= odOeN(donePinEnable, doneDriveLow);
    end
  end

  // global strobes: safe values held from reset through configuration; released in phases one and two
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      outEnable_reg <= 1'b0;
      setReset_reg  <= 1'b1;
      gwb_reg       <= 1'b1;
    end
    else
    begin
      case (state_next)
        config_seq_pkg::ST_WAKE_OUTPUTS:
        begin
          outEnable_reg <= 1'b1;
          setReset_reg  <= 1'b1;
          gwb_reg       <= 1'b1;
        end
        config_seq_pkg::ST_WAKE_RELEASE,
        config_seq_pkg::ST_WAKE_SETTLE,
        config_seq_pkg::ST_WAKE_DONE,
        config_seq_pkg::ST_USER:
        begin
          outEnable_reg <= 1'b1;
          setReset_reg  <= 1'b0;
          gwb_reg       <= 1'b0;
        end
        default:
        begin
          outEnable_reg <= 1'b0;
          setReset_reg  <= 1'b1;
          gwb_reg       <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
      doneBit_reg <= 1'b0;
    else if (state_next == config_seq_pkg::ST_INIT)
      doneBit_reg <= 1'b0;
    else if (state_reg == config_seq_pkg::ST_CONFIG &&
             state_next == config_seq_pkg::ST_WAKE_OUTPUTS)
      doneBit_reg <= 1'b1;
  end

  // spi flash is only a fallback when internal memory is blank
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      fetch_reg   <= 1'b0;
      fromSpi_reg <= 1'b0;
    end
    else
    begin
      fetch_reg   <= state_next == config_seq_pkg::ST_CONFIG &&
                     sourceValid;
      fromSpi_reg <= !nvmConfigValid && spiConfigValid;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      sramClear_reg <= 1'b0;
      user_reg      <= 1'b0;
      error_reg     <= 1'b0;
    end
    else
    begin
      sramClear_reg <= state_next == config_seq_pkg::ST_INIT &&
                       initDriveLow;
      user_reg      <= state_next == config_seq_pkg::ST_USER;
      error_reg     <= state_next == config_seq_pkg::ST_ERROR;
    end
  end

  // user flops with set/reset enabled take their defined value
  for (genvar g = 0; g < config_seq_pkg::USER_FF_COUNT; g++)
  begin : gen_user_ff
    always_ff @(posedge clock)
    begin
      if (!rstn)
        ffQ_reg[g] <= config_seq_pkg::USER_FF_RESET[g];
      else if (setReset_reg && forceEnableMask[g])
        ffQ_reg[g] <= config_seq_pkg::USER_FF_FORCE_VALUE[g];
      else
        ffQ_reg[g] <= userFfD[g];
    end
  end

  // gated combinationally so no write slips through on a late edge
  assign userRamWe = userRamWeIn && !gwb_reg;

  assign initStatusOut       = 1'b0;
  assign initStatusOeN       = initOeN_reg;
  assign doneOut             = 1'b0;
  assign doneOeN             = doneOeN_reg;
  assign ioHighZ             = !outEnable_reg;
  assign globalOutputEnable  = outEnable_reg;
  assign globalSetReset      = setReset_reg;
  assign globalRamWriteBlock = gwb_reg;
  assign internalDone        = doneBit_reg;
  assign fetchRequest        = fetch_reg;
  assign fetchFromSpi        = fromSpi_reg;
  assign sramClear           = sramClear_reg;
  assign userMode            = user_reg;
  assign configError         = error_reg;
  assign userFfQ             = ffQ_reg;

endmodule : config_state_sequencer

/* config_state_sequencer_assertions.sv */
`timescale 1ns/1ps

module config_state_sequencer_checker (
  input wire logic       clock,
  input wire logic       rstn,
  input wire logic       initStatusOeN,
  input wire logic       doneIn,
  input wire logic       doneOeN,
  input wire logic       reconfigureRequestPinN,
  input wire logic       initStatusPinEnable,
  input wire logic       donePinEnable,
  input wire logic       sramClear,
  input wire logic       ioHighZ,
  input wire logic       globalOutputEnable,
  input wire logic       globalSetReset,
  input wire logic       globalRamWriteBlock,
  input wire logic       internalDone,
  input wire logic       userMode,
  input wire logic       configError,
  input wire logic [1:0] portOwner,
  input wire logic       portOwnerValid,
  input wire logic       sramReadGrant,
  input wire logic       userRamWeIn,
  input wire logic       userRamWe,
  input wire logic [7:0] forceEnableMask,
  input wire logic [7:0] userFfQ
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  // reset itself is the cause here, so this one is never disabled
  reset_float_a: assert property (disable iff (1'b0) !rstn |=>
    initStatusOeN && doneOeN && ioHighZ && globalSetReset
    && globalRamWriteBlock) else $error("pins driven during reset");
  wake_outputs_a: assert property ($rose(internalDone) |->
    globalOutputEnable && !ioHighZ && globalSetReset)
    else $error("first wake phase wrong");
  wake_release_a: assert property ($rose(globalOutputEnable) |=>
    !globalSetReset && !globalRamWriteBlock)
    else $error("second wake phase wrong");
  ram_block_a: assert property (
    userRamWe == (userRamWeIn && !globalRamWriteBlock))
    else $error("ram write leaks past block");
  flop_force_a: assert property (globalSetReset[*2] |->
    ((userFfQ ^ config_seq_pkg::USER_FF_FORCE_VALUE) & forceEnableMask)
    == 8'h00) else $error("flops not forced");
  done_wait_a: assert property (
    (donePinEnable && !doneIn)[*3] |=> !$rose(userMode))
    else $error("user mode while done held low");
  done_nowait_a: assert property (
    $rose(internalDone) && !donePinEnable |-> ##4 userMode)
    else $error("wake stalled with done disabled");
  reinit_a: assert property (
    userMode && !reconfigureRequestPinN && initStatusPinEnable |->
    ##[1:4] (sramClear && !userMode && !initStatusOeN))
    else $error("no re-init on request");
  error_low_a: assert property (configError && initStatusPinEnable |->
    !initStatusOeN && !userMode && !globalOutputEnable)
    else $error("error not flagged");
  sram_read_a: assert property (sramReadGrant |->
    portOwnerValid && portOwner == 2'h0)
    else $error("sram read by wrong port");
endmodule : config_state_sequencer_checker

bind config_state_sequencer config_state_sequencer_checker i_checker (.*);

/* init_done_partner.sv */
`timescale 1ns/1ps

module init_done_partner #(
  parameter int LOAD_CYCLES = 20
) (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic initStatusOut,
  input  wire logic initStatusOeN,
  input  wire logic doneOut,
  input  wire logic doneOeN,
  input  wire logic fetchRequest,
  input  wire logic holdInitLow,
  input  wire logic holdDoneLow,
  input  wire logic injectError,
  output logic      initStatusIn,
  output logic      doneIn,
  output logic      cfgDataDone,
  output logic      cfgDataError
);
  logic [7:0] loadCnt_reg;

  // pull-ups: a line is high unless some party pulls it low
  assign initStatusIn = (initStatusOeN | initStatusOut) & !holdInitLow;
  assign doneIn = (doneOeN | doneOut) & !holdDoneLow;

  // loader answers once per fetch; saturates so it never repeats
  always_ff @(posedge clock)
  begin
    if (!rstn || !fetchRequest)
      loadCnt_reg <= 8'h00;
    else if (loadCnt_reg != 8'hff)
      loadCnt_reg <= loadCnt_reg + 8'h01;
  end

  assign cfgDataDone = fetchRequest && loadCnt_reg == 8'(LOAD_CYCLES)
    && !injectError;
  assign cfgDataError = fetchRequest && loadCnt_reg == 8'(LOAD_CYCLES)
    && injectError;
endmodule : init_done_partner

/* config_state_sequencer_tb.sv */
`timescale 1ns/1ps

module config_state_sequencer_tb;
  logic       clock, rstn, initStatusIn, initStatusOut, initStatusOeN;
  logic       doneIn, doneOut, doneOeN, reconfigureRequestPinN;
  logic       initStatusPinEnable, donePinEnable, nvmConfigValid;
  logic       spiConfigValid, fetchRequest, fetchFromSpi, cfgDataDone;
  logic       cfgDataError, sramClear, ioHighZ, globalOutputEnable;
  logic       globalSetReset, globalRamWriteBlock, internalDone, userMode;
  logic       configError, transparentMode, nvmReadReq, nvmWriteReq;
  logic       sramReadReq, sramWriteReq, portOwnerValid, nvmReadGrant;
  logic       nvmWriteGrant, sramReadGrant, sramWriteGrant, userRamWeIn;
  logic       userRamWe, holdInitLow, holdDoneLow, injectError;
  logic [3:0] portRequest, portReload;
  logic [1:0] portOwner;
  logic [7:0] userFfD, forceEnableMask, userFfQ;
  int         failures, checked;

  config_state_sequencer i_config_state_sequencer (.*);
  init_done_partner i_init_done_partner (.*);

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task summarize;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  task check(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : check

  task ticks(input int n);
    repeat (n) @(negedge clock);
  endtask : ticks

  // bounded wait on one status output
  task waitFor(input int sel, input logic val);
    logic s;
    for (int i = 0; i < 400; i++)
    begin
      @(negedge clock);
      case (sel)
        0: s = fetchRequest;
        1: s = userMode;
        2: s = internalDone;
        3: s = configError;
        default: s = sramClear;
      endcase
      if (s === val)
        return;
    end
    failures++;
    $display("[FAIL] %0t wait ran out", $time);
    summarize();
  endtask : waitFor

  task access(input int p, input int op, input logic tr, input logic exp);
    logic [3:0] g;
    transparentMode = tr;
    portRequest = 4'h1 << p;
    ticks(1);
    {sramWriteReq, sramReadReq, nvmWriteReq, nvmReadReq} = 4'h1 << op;
    ticks(2);
    g = {sramWriteGrant, sramReadGrant, nvmWriteGrant, nvmReadGrant};
    check(8'({portOwnerValid, portOwner}), 8'(4 + p), "owner");
    check(8'(g), exp ? 8'(1 << op) : 8'h00, "grant");
    {sramWriteReq, sramReadReq, nvmWriteReq, nvmReadReq} = 4'h0;
    portRequest = 4'h0;
    ticks(2);
  endtask : access

  initial
  begin
    {rstn, holdInitLow, holdDoneLow, injectError} = 4'h0;
    {reconfigureRequestPinN, initStatusPinEnable, donePinEnable} = 3'h7;
    {nvmConfigValid, spiConfigValid, transparentMode} = 3'h4;
    {nvmReadReq, nvmWriteReq, sramReadReq, sramWriteReq} = 4'h0;
    {portRequest, portReload} = 8'h00;
    userRamWeIn = 1'b1;
    userFfD = 8'ha5;
    forceEnableMask = 8'hff;
    failures = 0;
    checked = 0;
    ticks(16);
    check(8'({ioHighZ, initStatusOeN, doneOeN, globalSetReset,
      globalRamWriteBlock, globalOutputEnable}), 8'h3e, "reset");
    check(userFfQ, config_seq_pkg::USER_FF_RESET, "ff reset");
    holdInitLow = 1'b1;
    rstn = 1'b1;
    ticks(1);
    check(8'({initStatusOeN, doneOeN, sramClear}), 8'h01, "entry");
    ticks(60);
    check(8'({sramClear, fetchRequest}), 8'h00, "init held");
    holdInitLow = 1'b0;
    waitFor(0, 1'b1);
    check(8'({fetchFromSpi, globalOutputEnable, globalSetReset,
      userRamWe}), 8'h02, "config");
    check(userFfQ, config_seq_pkg::USER_FF_FORCE_VALUE, "forced");
    holdDoneLow = 1'b1;
    waitFor(2, 1'b1);
    check(8'({globalOutputEnable, ioHighZ, globalSetReset}), 8'h05,
      "wake one");
    ticks(1);
    check(8'({globalSetReset, globalRamWriteBlock}), 8'h00, "two");
    ticks(10);
    check(8'({userMode, doneOeN}), 8'h01, "done stall");
    holdDoneLow = 1'b0;
    waitFor(1, 1'b1);
    ticks(2);
    check(userFfQ, userFfD, "user flops");
    check(8'(userRamWe), 8'h01, "ram write");
    access(3, 1, 1'b1, 1'b1);
    access(3, 3, 1'b1, 1'b0);
    check(8'(userMode), 8'h01, "user stays");
    reconfigureRequestPinN = 1'b0;
    waitFor(4, 1'b1);
    check(8'({initStatusOeN, doneOeN, userMode, internalDone}), 8'h00,
      "reinit");
    {reconfigureRequestPinN, donePinEnable, injectError} = 3'b101;
    waitFor(3, 1'b1);
    ticks(5);
    check(8'({initStatusOeN, globalOutputEnable, userMode}), 8'h00,
      "error");
    portRequest = 4'h1;
    ticks(2);
    portReload = 4'h1;
    {nvmConfigValid, injectError} = 2'b00;
    waitFor(4, 1'b1);
    {portReload, portRequest} = 8'h00;
    ticks(100);
    check(8'({fetchRequest, internalDone}), 8'h00, "no source");
    check(8'(doneOeN), 8'h01, "done float");
    // offline access table while stalled in configuration
    for (int p = 0; p < 4; p++)
      for (int op = 0; op < 4; op++)
        access(p, op, 1'b0, p == 0 || (p != 3 && op != 2));
    // only enabled flops are forced; the rest follow their data
    forceEnableMask = 8'hf0;
    ticks(2);
    check(userFfQ, (config_seq_pkg::USER_FF_FORCE_VALUE & 8'hf0) |
      (userFfD & 8'h0f), "masked force");
    spiConfigValid = 1'b1;
    waitFor(0, 1'b1);
    check(8'(fetchFromSpi), 8'h01, "spi source");
    waitFor(2, 1'b1);
    ticks(4);
    check(8'(userMode), 8'h01, "no done wait");
    summarize();
  end
endmodule : config_state_sequencer_tb
